// file: logic/lo_driver_control_latches.sv
// Bus-addressed control and bias-converter latches of the oscillator driver board
`timescale 1ns/1ps
`default_nettype none
module lo_driver_control_latches (
    input wire logic clock,
    input wire logic rstn,
    input wire lo_ctrl_pkg::bus_req_t bus,
    output logic ctrl_sel_n,
    output logic dac_sel_n,
    output logic [2:0] bias_on_n,
    output logic peak_src_on_n,
    output logic driver_off,
    output logic sweep_relay_on,
    output logic filter_drive_on,
    output logic peak_route,
    output logic [lo_ctrl_pkg::CODE_W-1:0] dac_code
);
    import lo_ctrl_pkg::*;

    //==========================================================================
    // Address decode and strobe tracking
    //==========================================================================
    logic dec_ctrl;
    logic dec_dac;
    logic ctrl_sel_n_reg;
    logic dac_sel_n_reg;
    logic [DATA_W-1:0] hold_reg;
    logic ctrl_load;
    logic dac_load;
    logic load_a;
    logic load_b;

    // Decoder outputs track address and write-valid together
    assign dec_ctrl = bus.valid && (bus.addr == CTRL_ADDR);
    assign dec_dac = bus.valid && (bus.addr == DAC_ADDR);

    // Selects are registered so the pins come from flops
    always_ff @(posedge clock) begin
        if (!rstn) begin
            ctrl_sel_n_reg <= 1'b1;
            dac_sel_n_reg <= 1'b1;
        end else begin
            ctrl_sel_n_reg <= ~dec_ctrl;
            dac_sel_n_reg <= ~dec_dac;
        end
    end

    // Data is held during the strobe; the bus may drop it with the trailing edge
    always_ff @(posedge clock) begin
        if (!rstn) begin
            hold_reg <= '0;
        end else if (dec_ctrl || dec_dac) begin
            hold_reg <= bus.data;
        end
    end

    // Load on the select's return high, i.e. the strobe's trailing edge
    assign ctrl_load = !ctrl_sel_n_reg && !dec_ctrl;
    assign dac_load = !dac_sel_n_reg && !dec_dac;
    // Exactly one converter byte per write: bit 6 high with bit 7 low picks A
    assign load_a = dac_load && hold_reg[BIT_SEL_A] && !hold_reg[BIT_SEL_B];
    assign load_b = dac_load && !load_a;

    //==========================================================================
    // Latches
    //==========================================================================
    logic [DATA_W-1:0] ctrl_q;
    logic [DATA_W-1:0] dac_a_q;
    logic [DATA_W-1:0] dac_b_q;

    byte_latch #(.WIDTH(DATA_W), .RESET_VALUE(CTRL_RESET)) u_ctrl (
        .clock(clock),
        .rstn(rstn),
        .load(ctrl_load),
        .d(hold_reg),
        .q(ctrl_q)
    );

    byte_latch #(.WIDTH(DATA_W), .RESET_VALUE(DAC_RESET)) u_dac_a (
        .clock(clock),
        .rstn(rstn),
        .load(load_a),
        .d(hold_reg),
        .q(dac_a_q)
    );

    byte_latch #(.WIDTH(DATA_W), .RESET_VALUE(DAC_RESET)) u_dac_b (
        .clock(clock),
        .rstn(rstn),
        .load(load_b),
        .d(hold_reg),
        .q(dac_b_q)
    );

    //==========================================================================
    // Derived drives, registered together with the latch loads
    //==========================================================================
    logic filter_reg;
    logic peak_reg;
    logic [CODE_W-1:0] code_reg;

    // Filter drive is the inverse of the sweep bit; kept as its own flop
    always_ff @(posedge clock) begin
        if (!rstn) begin
            filter_reg <= ~CTRL_RESET[BIT_SWEEP];
        end else if (ctrl_load) begin
            filter_reg <= ~hold_reg[BIT_SWEEP];
        end
    end

    // Peaking route follows the byte loaded into latch A
    always_ff @(posedge clock) begin
        if (!rstn) begin
            peak_reg <= ~DAC_RESET[BIT_PK_LO] & ~DAC_RESET[BIT_SEL_B];
        end else if (load_a) begin
            peak_reg <= ~hold_reg[BIT_PK_LO] & ~hold_reg[BIT_SEL_B];
        end
    end

    // Both bytes form one converter code, B high and A low
    always_ff @(posedge clock) begin
        if (!rstn) begin
            code_reg <= {DAC_RESET, DAC_RESET};
        end else if (load_a) begin
            code_reg <= {dac_b_q, hold_reg};
        end else if (load_b) begin
            code_reg <= {hold_reg, dac_a_q};
        end
    end

    // Bits 4 and 7 of the control byte reach no output
    assign ctrl_sel_n = ctrl_sel_n_reg;
    assign dac_sel_n = dac_sel_n_reg;
    assign bias_on_n = {ctrl_q[BIT_BIAS3], ctrl_q[BIT_BIAS2], ctrl_q[BIT_BIAS1]};
    assign peak_src_on_n = ctrl_q[BIT_PEAK];
    assign driver_off = ctrl_q[BIT_DRV];
    assign sweep_relay_on = ctrl_q[BIT_SWEEP];
    assign filter_drive_on = filter_reg;
    assign peak_route = peak_reg;
    assign dac_code = code_reg;

    //==========================================================================
    // Assertions
    //==========================================================================
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    a_ctrl_sel_low: assert property (dec_ctrl |=> !ctrl_sel_n)
        else $error("control select not low during address 72 write");
    a_dac_sel_low: assert property (dec_dac |=> !dac_sel_n)
        else $error("converter select not low during address 7e write");
    a_ctrl_capture: assert property ($rose(ctrl_sel_n) |-> ctrl_q == $past(hold_reg))
        else $error("control latch missed data on select rise");
    a_one_dac_byte: assert property (dac_load |=> !($changed(dac_a_q) && $changed(dac_b_q)))
        else $error("both converter bytes changed on one write");
    // The load edge is the one before the select is seen high, so both are judged at the same edge
    a_trailing_only: assert property (!$rose(ctrl_sel_n) |-> $stable(ctrl_q))
        else $error("control latch changed without a trailing edge");
    a_bias_map: assert property ($rose(ctrl_sel_n) |-> bias_on_n == $past(hold_reg[2:0]))
        else $error("bias switch drive does not follow bits 0 to 2");
    a_peak_map: assert property ($rose(ctrl_sel_n) |-> peak_src_on_n == $past(hold_reg[BIT_PEAK]))
        else $error("peaking source switch does not follow bit 3");
    a_driver_gate: assert property ($rose(ctrl_sel_n) |-> driver_off == $past(hold_reg[BIT_DRV]))
        else $error("driver gate does not follow bit 5");
    a_sweep_relay: assert property ($rose(ctrl_sel_n) |-> sweep_relay_on == $past(hold_reg[BIT_SWEEP]))
        else $error("sweep relay does not follow bit 6");
    a_filter_inverse: assert property (filter_drive_on == !sweep_relay_on)
        else $error("filter drive not inverse of sweep relay");
    a_code_join: assert property ((load_a || load_b) |=> dac_code == {dac_b_q, dac_a_q})
        else $error("converter code does not join both bytes");
    a_peak_route: assert property (load_a |=> peak_route == (!dac_a_q[BIT_PK_LO] && !dac_a_q[BIT_SEL_B]))
        else $error("peaking route wrong after latch A load");
    a_reset_ones: assert property ($rose(rstn) |-> ctrl_q == CTRL_RESET)
        else $error("control latch not all ones after reset");

    c_ctrl_write: cover property (dec_ctrl ##1 !dec_ctrl);
    c_load_a: cover property (load_a);
    c_load_b: cover property (load_b);
    c_peak_on: cover property ($rose(peak_route));
endmodule
`default_nettype wire

// file: shared/lo_ctrl_pkg.sv
// Constants and types shared by the local-oscillator driver control latches
//==============================================================================
//==============================================================================
package lo_ctrl_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int CODE_W = 2 * DATA_W;

    // Write addresses
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h72;
    localparam logic [ADDR_W-1:0] DAC_ADDR = 8'h7e;

    // Control latch bit positions
    localparam int BIT_BIAS1 = 0;
    localparam int BIT_BIAS2 = 1;
    localparam int BIT_BIAS3 = 2;
    localparam int BIT_PEAK = 3;
    localparam int BIT_DRV = 5;
    localparam int BIT_SWEEP = 6;

    // Converter byte fields
    localparam int BIT_PK_LO = 4;
    localparam int BIT_SEL_A = 6;
    localparam int BIT_SEL_B = 7;

    // Reset values
    localparam logic [DATA_W-1:0] CTRL_RESET = 8'hff;
    localparam logic [DATA_W-1:0] DAC_RESET = 8'h00;

    // One bus write request as seen on the instrument bus
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic valid;
    } bus_req_t;
endpackage

// file: logic/byte_latch.sv
// One bus-loaded byte latch with a synchronous reset value
`timescale 1ns/1ps
`default_nettype none
module byte_latch #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic load,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    // Holds its byte until the next load
    always_ff @(posedge clock) begin
        if (!rstn) begin
            q <= RESET_VALUE;
        end else if (load) begin
            q <= d;
        end
    end
endmodule
`default_nettype wire

// file: tb/bus_master_model.sv
// Instrument microcomputer model that issues write cycles on the parallel bus
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
    input wire logic clock,
    output var lo_ctrl_pkg::bus_req_t bus
);
    import lo_ctrl_pkg::*;
    initial begin
        bus = '0;
    end
    // Strobe stands for len edges with address and data held, then drops
    task automatic write_byte(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data, input int len);
        bus.addr <= addr;
        bus.data <= data;
        bus.valid <= 1'b1;
        repeat (len) @(posedge clock);
        // Released lines show the inverse, so a late capture of stale data cannot pass unseen
        bus.addr <= ~addr;
        bus.data <= ~data;
        bus.valid <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the oscillator driver control latches
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import lo_ctrl_pkg::*;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    bus_req_t bus;
    logic ctrl_sel_n;
    logic dac_sel_n;
    logic [2:0] bias_on_n;
    logic peak_src_on_n;
    logic driver_off;
    logic sweep_relay_on;
    logic filter_drive_on;
    logic peak_route;
    logic [CODE_W-1:0] dac_code;
    logic [7:0] exp_ctrl = CTRL_RESET;
    logic [7:0] exp_a = DAC_RESET;
    logic [7:0] exp_b = DAC_RESET;
    logic [7:0] ctrl_vals [6] = '{8'h00, 8'hff, 8'h6e, 8'h91, 8'hbf, 8'h40};
    logic [7:0] dac_vals [6] = '{8'h4f, 8'h3c, 8'h50, 8'h81, 8'hc7, 8'h6f};
    int fail_count = 0;
    int num_checks = 0;
    wire logic [25:0] outs = {ctrl_sel_n, dac_sel_n, bias_on_n, peak_src_on_n, driver_off,
        sweep_relay_on, filter_drive_on, peak_route, dac_code};

    always #12.5 clock = ~clock;

    bus_master_model bus_master_model_inst (.clock(clock), .bus(bus));
    lo_driver_control_latches lo_driver_control_latches_inst (.clock(clock), .rstn(rstn), .bus(bus),
        .ctrl_sel_n(ctrl_sel_n), .dac_sel_n(dac_sel_n), .bias_on_n(bias_on_n), .peak_src_on_n(peak_src_on_n),
        .driver_off(driver_off), .sweep_relay_on(sweep_relay_on), .filter_drive_on(filter_drive_on),
        .peak_route(peak_route), .dac_code(dac_code));

    //==========================================================================
    // Checking helpers
    function automatic logic [25:0] expect_outs(input logic csel, input logic dsel);
        return {csel, dsel, exp_ctrl[2:0], exp_ctrl[3], exp_ctrl[5], exp_ctrl[6], ~exp_ctrl[6],
            ~exp_a[4] & ~exp_a[7], exp_b, exp_a};
    endfunction

    task automatic check(input logic [25:0] seen, input logic [25:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // Select must still be low just after the strobe drops, with the latches still untouched
    task automatic write_check(input logic [7:0] addr, input logic [7:0] data, input int len);
        @(posedge clock);
        bus_master_model_inst.write_byte(addr, data, len);
        #1;
        check(outs, expect_outs(addr != CTRL_ADDR, addr != DAC_ADDR));
        if (addr == CTRL_ADDR) begin
            exp_ctrl = data;
        end else if (addr == DAC_ADDR && data[7:6] == 2'b01) begin
            exp_a = data;
        end else if (addr == DAC_ADDR) begin
            exp_b = data;
        end
        repeat (2) @(posedge clock);
        #1;
        check(outs, expect_outs(1'b1, 1'b1));
    endtask

    task automatic stop_test();
        if (fail_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    //==========================================================================
    // Test sequence
    initial begin
        repeat (10) @(posedge clock);
        rstn <= 1'b1;
        #1;
        check(outs, expect_outs(1'b1, 1'b1));
        // Every control bit both ways, unused bits 4 and 7 flipped against bits 1 to 3, 5 and 6
        for (int i = 0; i < 6; i++) begin
            write_check(CTRL_ADDR, ctrl_vals[i], i % 3 + 1);
        end
        // All four settings of bits 6 and 7, peaking flag set and cleared
        for (int i = 0; i < 6; i++) begin
            write_check(DAC_ADDR, dac_vals[i], i % 2 + 1);
        end
        // Peaking is routed now, so the controller zeroes the converter's high byte
        write_check(DAC_ADDR, 8'h00, 1);
        // Neighbouring and idle addresses must leave everything as it was, then a control write takes the driver off
        write_check(8'h73, 8'h00, 1);
        write_check(8'h7f, 8'h00, 2);
        write_check(8'h00, 8'h00, 1);
        write_check(CTRL_ADDR, 8'h2a, 1);
        // Degauss over: the controller puts the driver input back on
        write_check(CTRL_ADDR, 8'h0a, 1);
        // A second reset in mid-run brings back the safe state
        @(posedge clock);
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        exp_ctrl = CTRL_RESET;
        exp_a = DAC_RESET;
        exp_b = DAC_RESET;
        #1;
        check(outs, expect_outs(1'b1, 1'b1));
        // The first edges after release must not disturb the safe state
        repeat (2) @(posedge clock);
        #1;
        check(outs, expect_outs(1'b1, 1'b1));
        stop_test();
    end

    // Watchdog: the run needs about 100 cycles, so 2000 means a hang
    initial begin
        #(25 * 2000);
        fail_count++;
        stop_test();
    end
endmodule
`default_nettype wire
